/* File: verilog/bridge_clock_ctrl_and_cap_regs.sv */
`timescale 1ns/100ps
module bridge_clock_ctrl_and_cap_regs (
   // clock and reset
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   // axi4-lite write address and data
   input  wire logic [bridge_regs_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                               awvalid,
   output logic                                    awready,
   input  wire logic [bridge_regs_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                         wstrb,
   input  wire logic                               wvalid,
   output logic                                    wready,
   // axi4-lite write response
   output logic [1:0]                              bresp,
   output logic                                    bvalid,
   input  wire logic                               bready,
   // axi4-lite read
   input  wire logic [bridge_regs_pkg::ADDR_W-1:0] araddr,
   input  wire logic                               arvalid,
   output logic                                    arready,
   output logic [bridge_regs_pkg::DATA_W-1:0]      rdata,
   output logic [1:0]                              rresp,
   output logic                                    rvalid,
   input  wire logic                               rready,
   // straps and configuration loading
   input  wire logic                               reverse_strap,
   input  wire logic                               slot_id_enable,
   input  wire logic [15:0]                        card_vendor_id,
   input  wire logic [15:0]                        card_id,
   // bridge state
   input  wire logic                               in_d3hot,
   input  wire logic                               secondary_idle,
   input  wire logic                               primary_pending,
   input  wire logic                               l0s_request,
   input  wire logic                               rx_elec_idle,
   // link control outputs
   output logic                                    l0s_enter,
   output logic [1:0]                              scramble_ctrl,
   // secondary slot clocks
   output logic                                    slot_zero_clock_out,
   output logic                                    slot_one_clock_out,
   output logic                                    slot_two_clock_out,
   output logic                                    slot_three_clock_out
);
   import bridge_regs_pkg::*;

   clock_ctrl_t             ctrl;
   clock_ctrl_t             next_ctrl;
   logic                    reverse;
   logic                    next_reverse;
   logic                    stopped;
   logic                    next_stopped;
   logic                    divider;
   logic                    next_divider;
   logic [SLOT_COUNT-1:0]   slot_out;
   logic [SLOT_COUNT-1:0]   next_slot_out;
   logic                    next_l0s_enter;

   logic                    aw_held;
   logic                    next_aw_held;
   logic [ADDR_W-1:0]       aw_addr;
   logic [ADDR_W-1:0]       next_aw_addr;
   logic                    w_held;
   logic                    next_w_held;
   logic [DATA_W-1:0]       w_data;
   logic [DATA_W-1:0]       next_w_data;
   logic [3:0]              w_strb;
   logic [3:0]              next_w_strb;
   logic                    next_bvalid;
   logic [1:0]              next_bresp;
   logic                    next_rvalid;
   logic [1:0]              next_rresp;
   logic [DATA_W-1:0]       next_rdata;
   logic [DATA_W-1:0]       write_mask;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a[11:2] == CLOCK_CTRL_OFS[11:2]) ||
             (a[11:2] == SUBSYS_CAP_OFS[11:2]) ||
             (a[11:2] == SUBSYS_ID_OFS[11:2]) ||
             (a[11:2] == EXPRESS_CAP_OFS[11:2]);
   endfunction : is_mapped

   function automatic logic [DATA_W-1:0] read_word(
      input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] v;
      clock_ctrl_t       c;
      v = '0;
      c = ctrl;
      c.clock_stopped = stopped;
      if (a[11:2] == CLOCK_CTRL_OFS[11:2]) begin
         v = c;
      end else if (a[11:2] == SUBSYS_CAP_OFS[11:2]) begin
         v[7:0]  = SUBSYS_CAP_ID;
         v[15:8] = slot_id_enable ? NEXT_PTR_SLOT_ID
                                  : NEXT_PTR_EXPRESS;
      end else if (a[11:2] == SUBSYS_ID_OFS[11:2]) begin
         v = {card_id, card_vendor_id};
      end else if (a[11:2] == EXPRESS_CAP_OFS[11:2]) begin
         v[7:0]   = EXPRESS_CAP_ID;
         v[15:8]  = EXPRESS_NEXT_PTR;
         v[19:16] = EXPRESS_CAP_VER;
         v[23:20] = reverse ? PORT_TYPE_REVERSE
                            : PORT_TYPE_FORWARD;
         v[24]    = reverse;
         v[29:25] = INT_MSG_NUMBER;
      end
      return v;
   endfunction : read_word

   // handshakes: one write and one read in flight, answer blocks new ones
   assign awready = !aw_held && !bvalid;
   assign wready  = !w_held && !bvalid;
   assign arready = !rvalid;

   // only the documented writable bits pass, and only in bytes whose strobe is set
   assign write_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                        {8{w_strb[1]}}, {8{w_strb[0]}}} &
                       CLOCK_CTRL_RW_MASK;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_ctrl    = ctrl;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data = wdata;
         next_w_strb = wstrb;
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (aw_addr[11:2] == CLOCK_CTRL_OFS[11:2]) begin
            next_ctrl = clock_ctrl_t'((ctrl & ~write_mask) |
                                      (w_data & write_mask));
         end
      end
      if (!aresetn) begin
         next_aw_held = 1'b0;
         next_aw_addr = '0;
         next_w_held  = 1'b0;
         next_w_data  = '0;
         next_w_strb  = '0;
         next_bvalid  = 1'b0;
         next_bresp   = RESP_OKAY;
         next_ctrl    = clock_ctrl_t'(CLOCK_CTRL_RESET);
      end
   end

   always_ff @(posedge aclk) begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      ctrl    <= next_ctrl;
   end

   // read channel; unmapped words read zero with slverr
   always_comb begin
      next_rvalid = rvalid;
      next_rresp  = rresp;
      next_rdata  = rdata;
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rdata  = read_word(araddr);
         next_rresp  = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (!aresetn) begin
         next_rvalid = 1'b0;
         next_rresp  = RESP_OKAY;
         next_rdata  = '0;
      end
   end

   always_ff @(posedge aclk) begin
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
   end

   // bridge direction is sampled while reset is held, then frozen
   always_comb begin
      next_reverse = aresetn ? reverse : reverse_strap;
   end

   always_ff @(posedge aclk) begin
      reverse <= next_reverse;
   end

   // clock-run stop decision and slot clock generation
   always_comb begin
      next_stopped = 1'b0;
      if (ctrl.clkrun_enable) begin
         if (ctrl.clkrun_mode) begin
            next_stopped = secondary_idle && !primary_pending;
         end else begin
            next_stopped = in_d3hot;
         end
      end
      next_divider = !divider;
      for (int i = 0; i < SLOT_COUNT; i++) begin
         // reverse mode ignores the per-slot fields entirely
         next_slot_out[i] = !stopped && divider &&
            (reverse ||
             ctrl.slot_enable[2*i +: 2] != SLOT_CLOCK_OFF);
      end
      // gate the request on rx_elec_idle when l0s_need_idle is set so a busy receiver can hold L0s off
      next_l0s_enter = l0s_request &&
                       (!ctrl.l0s_need_idle || rx_elec_idle);
      if (!aresetn) begin
         next_stopped   = 1'b0;
         next_divider   = 1'b0;
         next_slot_out  = '0;
         next_l0s_enter = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      stopped   <= next_stopped;
      divider   <= next_divider;
      slot_out  <= next_slot_out;
      l0s_enter <= next_l0s_enter;
   end

   // slot clocks run at half of aclk; duty cycle set by the flop
   assign slot_zero_clock_out  = slot_out[0];
   assign slot_one_clock_out   = slot_out[1];
   assign slot_two_clock_out   = slot_out[2];
   assign slot_three_clock_out = slot_out[3];
   assign scramble_ctrl        = ctrl.scramble;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_slot_off;
      (!reverse && ctrl.slot_enable[1:0] == SLOT_CLOCK_OFF)
         |=> !slot_zero_clock_out;
   endproperty
   a_slot_off: assert property (p_slot_off)
      else $error("slot 0 clock not held low when disabled");

   property p_reverse_runs;
      (reverse && !stopped) |=> (slot_three_clock_out == $past(divider));
   endproperty
   a_reverse_runs: assert property (p_reverse_runs)
      else $error("slot clock field acted in reverse mode");

   property p_stop_holds_low;
      stopped |=> (slot_out == '0);
   endproperty
   a_stop_holds_low: assert property (p_stop_holds_low)
      else $error("slot clocks toggled while stopped");

   property p_clkrun_off;
      !ctrl.clkrun_enable |=> !stopped;
   endproperty
   a_clkrun_off: assert property (p_clkrun_off)
      else $error("clock stopped with protocol disabled");

   property p_mode_d3;
      (ctrl.clkrun_enable && !ctrl.clkrun_mode)
         |=> (stopped == $past(in_d3hot));
   endproperty
   a_mode_d3: assert property (p_mode_d3)
      else $error("mode 0 stop not tied to d3hot");

   property p_mode_idle;
      (ctrl.clkrun_enable && ctrl.clkrun_mode && secondary_idle &&
       !primary_pending) |=> stopped;
   endproperty
   a_mode_idle: assert property (p_mode_idle)
      else $error("idle bus did not stop clock in mode 1");

   property p_l0s_idle;
      (ctrl.l0s_need_idle && !rx_elec_idle) |=> !l0s_enter;
   endproperty
   a_l0s_idle: assert property (p_l0s_idle)
      else $error("l0s entered with receiver active");

   property p_l0s_free;
      (!ctrl.l0s_need_idle && l0s_request) |=> l0s_enter;
   endproperty
   a_l0s_free: assert property (p_l0s_free)
      else $error("l0s not entered with control clear");

   property p_reserved_zero;
      ctrl.rsvd_high == '0 && ctrl.rsvd_low == '0 && !ctrl.clock_stopped;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved control bits became set");

   property p_next_ptr;
      (arvalid && arready && araddr[11:2] == SUBSYS_CAP_OFS[11:2])
         |=> (rvalid && rdata[15:0] == {($past(slot_id_enable) ?
              NEXT_PTR_SLOT_ID : NEXT_PTR_EXPRESS), SUBSYS_CAP_ID});
   endproperty
   a_next_ptr: assert property (p_next_ptr)
      else $error("subsystem capability header wrong");

   property p_port_type;
      (arvalid && arready && araddr[11:2] == EXPRESS_CAP_OFS[11:2])
         |=> (rvalid && rdata[23:20] == (reverse ? PORT_TYPE_REVERSE :
              PORT_TYPE_FORWARD) && rdata[24] == reverse &&
              rdata[15:0] == 16'hf010 && rdata[31:25] == '0);
   endproperty
   a_port_type: assert property (p_port_type)
      else $error("express capability word wrong");

   // status shows the stop flop as it stood when the read was taken
   property p_ctrl_read;
      (arvalid && arready && araddr[11:2] == CLOCK_CTRL_OFS[11:2])
         |=> (rdata[13] == $past(stopped) && rdata[31:19] == '0 &&
              rdata[12:8] == '0);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("clock control read shows wrong status");

   property p_card_ids;
      (arvalid && arready && araddr[11:2] == SUBSYS_ID_OFS[11:2])
         |=> (rdata[15:0] == $past(card_vendor_id) &&
              rdata[31:16] == $past(card_id));
   endproperty
   a_card_ids: assert property (p_card_ids)
      else $error("card identifier word wrong");

   // a strap that moved after reset would flip the reported port type
   property p_strap_frozen;
      aresetn |=> $stable(reverse);
   endproperty
   a_strap_frozen: assert property (p_strap_frozen)
      else $error("bridge direction changed out of reset");

   property p_clkrun_write;
      (aw_held && w_held && aw_addr[11:2] == CLOCK_CTRL_OFS[11:2] &&
       w_strb[1]) |=> (ctrl.clkrun_enable == $past(w_data[14]));
   endproperty
   a_clkrun_write: assert property (p_clkrun_write)
      else $error("clock-run enable write did not land");

   property p_scramble_write;
      (aw_held && w_held && aw_addr[11:2] == CLOCK_CTRL_OFS[11:2] &&
       w_strb[2]) |=> (scramble_ctrl == $past(w_data[18:17]));
   endproperty
   a_scramble_write: assert property (p_scramble_write)
      else $error("scramble field write did not land");

   property p_unmapped_read;
      (arvalid && arready && !is_mapped(araddr))
         |=> (rdata == '0 && rresp == RESP_SLVERR);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read returned data or okay");

endmodule : bridge_clock_ctrl_and_cap_regs

/* File: common/bridge_regs_pkg.sv */
package bridge_regs_pkg;

   localparam int          ADDR_W             = 12;
   localparam int          DATA_W             = 32;

   // register byte offsets
   localparam logic [11:0] CLOCK_CTRL_OFS     = 12'h0a4;
   localparam logic [11:0] SUBSYS_CAP_OFS     = 12'h0a8;
   localparam logic [11:0] SUBSYS_ID_OFS      = 12'h0ac;
   localparam logic [11:0] EXPRESS_CAP_OFS    = 12'h0b0;

   // secondary clock control: writable bits and value after reset
   localparam logic [31:0] CLOCK_CTRL_RW_MASK = 32'h0007c0ff;
   localparam logic [31:0] CLOCK_CTRL_RESET   = 32'h00010000;
   localparam logic [1:0]  SLOT_CLOCK_OFF     = 2'h3;
   localparam int          SLOT_COUNT         = 4;

   // capability chain constants
   localparam logic [7:0]  SUBSYS_CAP_ID      = 8'h0d;
   localparam logic [7:0]  NEXT_PTR_EXPRESS   = 8'hb0;
   localparam logic [7:0]  NEXT_PTR_SLOT_ID   = 8'ha0;
   localparam logic [7:0]  EXPRESS_CAP_ID     = 8'h10;
   localparam logic [7:0]  EXPRESS_NEXT_PTR   = 8'hf0;
   localparam logic [3:0]  EXPRESS_CAP_VER    = 4'h1;
   localparam logic [4:0]  INT_MSG_NUMBER     = 5'h00;

   // device/port type encodings
   localparam logic [3:0]  PORT_ENDPOINT      = 4'h0;
   localparam logic [3:0]  PORT_LEGACY_EP     = 4'h1;
   localparam logic [3:0]  PORT_ROOT          = 4'h4;
   localparam logic [3:0]  PORT_SWITCH_UP     = 4'h5;
   localparam logic [3:0]  PORT_SWITCH_DOWN   = 4'h6;
   localparam logic [3:0]  PORT_TYPE_FORWARD  = 4'h7;
   localparam logic [3:0]  PORT_TYPE_REVERSE  = 4'h8;

   // bus responses
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;

   typedef struct packed {
      logic [12:0] rsvd_high;
      logic [1:0]  scramble;
      logic        l0s_need_idle;
      logic        clkrun_mode;
      logic        clkrun_enable;
      logic        clock_stopped;
      logic [4:0]  rsvd_low;
      logic [7:0]  slot_enable;
   } clock_ctrl_t;

endpackage : bridge_regs_pkg

/* File: dv/cfg_host_model.sv */
`timescale 1ns/100ps
module cfg_host_model (
   // clock
   input  wire logic                               aclk,
   // write channels
   output logic [bridge_regs_pkg::ADDR_W-1:0]      awaddr,
   output logic                                    awvalid,
   input  wire logic                               awready,
   output logic [bridge_regs_pkg::DATA_W-1:0]      wdata,
   output logic [3:0]                              wstrb,
   output logic                                    wvalid,
   input  wire logic                               wready,
   input  wire logic                               bvalid,
   output logic                                    bready,
   // read channels
   output logic [bridge_regs_pkg::ADDR_W-1:0]      araddr,
   output logic                                    arvalid,
   input  wire logic                               arready,
   input  wire logic                               rvalid,
   output logic                                    rready
);
   import bridge_regs_pkg::*;

   initial begin
      awaddr  = '0;
      awvalid = 1'b0;
      wdata   = '0;
      wstrb   = 4'h0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      araddr  = '0;
      arvalid = 1'b0;
      rready  = 1'b0;
   end

   // aw and w offered together, each dropped at its own handshake edge
   task write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
              input logic [3:0] s, input int gap);
      repeat (gap + 1) @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : write

   task read(input logic [ADDR_W-1:0] a, input int gap);
      repeat (gap + 1) @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask : read
endmodule : cfg_host_model

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import bridge_regs_pkg::*;
   logic        aclk, aresetn, reverse_strap, slot_id_enable, in_d3hot;
   logic        secondary_idle, primary_pending, l0s_request, rx_elec_idle;
   logic        awvalid, awready, wvalid, wready, bvalid, bready, l0s_enter;
   logic        arvalid, arready, rvalid, rready;
   logic        slot_zero_clock_out, slot_one_clock_out;
   logic        slot_two_clock_out, slot_three_clock_out;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [15:0] card_vendor_id, card_id;
   logic [3:0]  wstrb, slots;
   logic [1:0]  bresp, rresp, scramble_ctrl;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int          miscompares, n_compared, cycles, seed;

   assign slots = {slot_three_clock_out, slot_two_clock_out,
                   slot_one_clock_out, slot_zero_clock_out};

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   bridge_clock_ctrl_and_cap_regs i_bridge_clock_ctrl_and_cap_regs (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .reverse_strap,
      .slot_id_enable, .card_vendor_id, .card_id, .in_d3hot,
      .secondary_idle, .primary_pending, .l0s_request, .rx_elec_idle,
      .l0s_enter, .scramble_ctrl, .slot_zero_clock_out,
      .slot_one_clock_out, .slot_two_clock_out, .slot_three_clock_out);

   cfg_host_model i_cfg_host_model (
      .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rvalid,
      .rready);

   task tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   task chk(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] e);
      rq.push_back({r, e});
      i_cfg_host_model.read(a, $random(seed) & 3);
   endtask : rd

   task wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
           input logic [1:0] r);
      bq.push_back(r);
      i_cfg_host_model.write(a, v, s, $random(seed) & 3);
   endtask : wr

   // slots that run must go high in the four cycles after a four-cycle settle, stopped ones never
   task clk_chk(input logic [3:0] e);
      logic [3:0] hi;
      hi = 4'h0;
      repeat (4) @(posedge aclk);
      repeat (4) begin
         @(negedge aclk);
         hi = hi | slots;
      end
      chk({30'h0, hi}, {30'h0, e});
      @(posedge aclk);
   endtask : clk_chk

   task lz(input logic req, input logic idle, input logic e);
      l0s_request  <= req;
      rx_elec_idle <= idle;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({33'h0, l0s_enter}, {33'h0, e});
      @(posedge aclk);
   endtask : lz

   // strap is only captured while reset is low
   task reset_dut(input logic rev);
      aresetn       <= 1'b0;
      reverse_strap <= rev;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : reset_dut

   always @(posedge aclk) begin
      if (aresetn && bvalid && bready) begin
         chk({32'h0, bresp}, {32'h0, bq.pop_front()});
      end
      if (aresetn && rvalid && rready) begin
         chk({rresp, rdata}, rq.pop_front());
      end
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial begin
      seed = 32'h946e;
      {miscompares, n_compared, cycles} = '0;
      {aresetn, reverse_strap, slot_id_enable, in_d3hot} = 4'h0;
      {secondary_idle, primary_pending, l0s_request, rx_elec_idle} = 4'h0;
      card_vendor_id = $random(seed);
      card_id = $random(seed);
      reset_dut(1'b0);
      rd(CLOCK_CTRL_OFS, RESP_OKAY, CLOCK_CTRL_RESET);
      clk_chk(4'hf);
      rd(SUBSYS_CAP_OFS, RESP_OKAY, 32'h0000b00d);
      slot_id_enable <= 1'b1;
      rd(SUBSYS_CAP_OFS, RESP_OKAY, 32'h0000a00d);
      rd(SUBSYS_ID_OFS, RESP_OKAY, {card_id, card_vendor_id});
      rd(EXPRESS_CAP_OFS, RESP_OKAY, 32'h0071f010);
      wr(SUBSYS_CAP_OFS, 32'hffffffff, 4'hf, RESP_OKAY);
      rd(SUBSYS_CAP_OFS, RESP_OKAY, 32'h0000a00d);
      wr(EXPRESS_CAP_OFS, 32'hffffffff, 4'hf, RESP_OKAY);
      rd(EXPRESS_CAP_OFS, RESP_OKAY, 32'h0071f010);
      wr(12'h0c0, 32'hffffffff, 4'hf, RESP_SLVERR);
      rd(12'h0c0, RESP_SLVERR, 32'h0);
      // idle low and d3hot low keep the stop bit clear for any random value
      repeat (4) begin
         d = $random(seed);
         wr(CLOCK_CTRL_OFS, d, 4'hf, RESP_OKAY);
         rd(CLOCK_CTRL_OFS, RESP_OKAY, d & CLOCK_CTRL_RW_MASK);
      end
      wr(CLOCK_CTRL_OFS, 32'h00070000, 4'hf, RESP_OKAY);
      @(negedge aclk);
      chk({32'h0, scramble_ctrl}, 34'h3);
      wr(CLOCK_CTRL_OFS, 32'hffffffff, 4'h1, RESP_OKAY);
      rd(CLOCK_CTRL_OFS, RESP_OKAY, 32'h000700ff);
      clk_chk(4'h0);
      wr(CLOCK_CTRL_OFS, 32'h000100e7, 4'hf, RESP_OKAY);
      clk_chk(4'h6);
      secondary_idle <= 1'b1;
      wr(CLOCK_CTRL_OFS, 32'h0001c000, 4'hf, RESP_OKAY);
      rd(CLOCK_CTRL_OFS, RESP_OKAY, 32'h0001e000);
      clk_chk(4'h0);
      primary_pending <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(CLOCK_CTRL_OFS, RESP_OKAY, 32'h0001c000);
      clk_chk(4'hf);
      in_d3hot <= 1'b1;
      wr(CLOCK_CTRL_OFS, 32'h00014000, 4'hf, RESP_OKAY);
      rd(CLOCK_CTRL_OFS, RESP_OKAY, 32'h00016000);
      clk_chk(4'h0);
      wr(CLOCK_CTRL_OFS, 32'h00010000, 4'hf, RESP_OKAY);
      rd(CLOCK_CTRL_OFS, RESP_OKAY, 32'h00010000);
      clk_chk(4'hf);
      {in_d3hot, secondary_idle, primary_pending} <= 3'h0;
      lz(1'b1, 1'b0, 1'b0);
      lz(1'b1, 1'b1, 1'b1);
      lz(1'b0, 1'b1, 1'b0);
      wr(CLOCK_CTRL_OFS, 32'h0, 4'hf, RESP_OKAY);
      lz(1'b1, 1'b0, 1'b1);
      // second reset mid-run: control word must come back to its reset value
      reset_dut(1'b1);
      rd(CLOCK_CTRL_OFS, RESP_OKAY, CLOCK_CTRL_RESET);
      rd(EXPRESS_CAP_OFS, RESP_OKAY, 32'h0181f010);
      wr(CLOCK_CTRL_OFS, 32'h000100ff, 4'hf, RESP_OKAY);
      clk_chk(4'hf);
      tally_and_finish();
   end
endmodule : testbench
